// ==== fpbsc_pkg.sv ====
// Constants, opcodes and types of the flash page buffer status command block.
package fpbsc_pkg;

	// Command opcodes.
	localparam logic [7:0] OPC_XFER_B1 = 8'h53;
	localparam logic [7:0] OPC_XFER_B2 = 8'h55;
	localparam logic [7:0] OPC_COMP_B1 = 8'h60;
	localparam logic [7:0] OPC_COMP_B2 = 8'h61;
	localparam logic [7:0] OPC_RWR_B1 = 8'h58;
	localparam logic [7:0] OPC_RWR_B2 = 8'h59;
	localparam logic [7:0] OPC_STATUS = 8'hD7;

	// Frame bit counts.
	localparam logic [5:0] OPC_LAST_BIT = 6'h07;
	localparam logic [5:0] CMD_LAST_BIT = 6'h1F;
	localparam logic [5:0] CMD_BITS = 6'h20;
	localparam int PAGE_W = 13;

	// Page index position inside the 24 address bits.
	localparam int PAGE_LSB_STD = 10;
	localparam int PAGE_LSB_BIN = 9;

	// Status byte one bit positions.
	localparam int SB_BUSY_N = 7;
	localparam int SB1_COMP = 6;
	localparam int SB1_DENS_LSB = 2;
	localparam int SB1_PROTECT = 1;
	localparam int SB1_PAGE_BIN = 0;

	// Status byte two bit positions.
	localparam int SB2_RES_HI = 6;
	localparam int SB2_EPE = 5;
	localparam int SB2_RES_LO = 4;
	localparam int SB2_LOCK_OK = 3;
	localparam int SB2_PS2 = 2;
	localparam int SB2_PS1 = 1;
	localparam int SB2_ES = 0;

	// Bit index within a status byte and byte select in the bit counter.
	localparam logic [2:0] BYTE_START = 3'h0;
	localparam int BYTE_SEL_BIT = 3;

	// Array operations requested from the memory core.
	typedef enum logic [1:0]
	{
		FPBSC_OP_XFER = 2'b00,
		FPBSC_OP_COMP = 2'b01,
		FPBSC_OP_PROG = 2'b10
	} fpbsc_op_e;

	// Sequencer states.
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b000,
		ST_XFER = 3'b001,
		ST_COMP = 3'b010,
		ST_RWX = 3'b011,
		ST_RWP = 3'b100
	} fpbsc_state_e;

	function automatic logic [PAGE_W-1:0] fpbsc_page(
		input logic [23:0] addr,
		input logic bin
	);
		fpbsc_page = bin ? addr[PAGE_LSB_BIN +: PAGE_W] :
			addr[PAGE_LSB_STD +: PAGE_W];
	endfunction : fpbsc_page

endpackage : fpbsc_pkg

// ==== fpbsc_top.sv ====
// Serial command front end and sequencer for page transfer, compare, rewrite.
`timescale 1ns/100ps

module fpbsc_top
	import fpbsc_pkg::*;
#(
	// Density code value is arbitrary.
	parameter logic [3:0] DENSITY_CODE = 4'h0
)
(
	// System clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Serial link.
	input wire logic sck_i,
	input wire logic cs_n_i,
	input wire logic si_i,
	output logic so_o,
	output logic so_oe_n_o,
	// Device state reported in status.
	input wire logic protect_i,
	input wire logic page_bin_i,
	input wire logic lockdown_allowed_i,
	input wire logic prog_suspended_buf_one_i,
	input wire logic prog_suspended_buf_two_i,
	input wire logic erase_suspended_i,
	input wire logic ext_busy_i,
	input wire logic ext_pe_done_i,
	input wire logic ext_pe_fail_i,
	input wire logic ext_pe_abort_i,
	// Memory core operation port.
	output logic arr_req_o,
	output fpbsc_op_e arr_op_o,
	output logic [PAGE_W-1:0] arr_page_o,
	output logic arr_buf_two_o,
	input wire logic arr_done_i,
	input wire logic arr_mismatch_i,
	input wire logic arr_fail_i,
	input wire logic arr_abort_i
);

	logic [5:0] bitcnt_r;
	logic [30:0] shift_r;
	logic [31:0] cmd_r;
	logic cmd_full_r;
	logic stat_act_r;
	logic [15:0] st_meta_r;
	logic [15:0] st_sync_r;
	logic [3:0] sbit_r;
	logic [7:0] byte_sh_r;
	logic [7:0] byte_sel;
	logic [2:0] cs_q_r;
	logic [2:0] full_q_r;
	logic cs_lvl_r;
	logic cs_rise;
	logic cs_fall;
	logic pending_r;
	logic start;
	logic [7:0] opc;
	logic busy;
	fpbsc_state_e state_r;
	logic comp_r;
	logic epe_r;
	logic [15:0] status_r;

	// Link side: chip select high holds the bit counters, flags and SO output in reset; shift_r, cmd_r and the synchronisers are not reset.
	always_ff @(posedge sck_i or posedge cs_n_i)
	begin
		if (cs_n_i)
			bitcnt_r <= 6'h00;
		else if (bitcnt_r != CMD_BITS)
			bitcnt_r <= bitcnt_r + 6'h01;
	end

	always_ff @(posedge sck_i)
	begin
		shift_r <= {shift_r[29:0], si_i};
	end

	// The command word stays put after the frame so the system side can
	// read it at leisure; it only changes when a later frame, status reads included, reaches 32 clocks.
	always_ff @(posedge sck_i)
	begin
		if (!cs_n_i && bitcnt_r == CMD_LAST_BIT)
			cmd_r <= {shift_r, si_i};
	end

	always_ff @(posedge sck_i or posedge cs_n_i)
	begin
		if (cs_n_i)
			cmd_full_r <= 1'b0;
		else if (bitcnt_r == CMD_LAST_BIT)
			cmd_full_r <= 1'b1;
	end

	always_ff @(posedge sck_i or posedge cs_n_i)
	begin
		if (cs_n_i)
			stat_act_r <= 1'b0;
		else if (bitcnt_r == OPC_LAST_BIT && {shift_r[6:0], si_i} == OPC_STATUS)
			stat_act_r <= 1'b1;
	end

	// Each status bit is an independent level, so per-bit synchronisers
	// are safe; a byte may mix old and new flags, never torn bits.
	always_ff @(posedge sck_i)
	begin
		st_meta_r <= status_r;
		st_sync_r <= st_meta_r;
	end

	assign byte_sel = sbit_r[BYTE_SEL_BIT] ? st_sync_r[7:0] : st_sync_r[15:8];

	always_ff @(negedge sck_i or posedge cs_n_i)
	begin
		if (cs_n_i)
			sbit_r <= 4'h0;
		else if (stat_act_r)
			sbit_r <= sbit_r + 4'h1;
	end

	always_ff @(negedge sck_i or posedge cs_n_i)
	begin
		if (cs_n_i)
		begin
			so_o <= 1'b0;
			byte_sh_r <= 8'h00;
		end
		else if (stat_act_r && sbit_r[2:0] == BYTE_START)
		begin
			so_o <= byte_sel[SB_BUSY_N];
			byte_sh_r <= {byte_sel[6:0], 1'b0};
		end
		else if (stat_act_r)
		begin
			so_o <= byte_sh_r[7];
			byte_sh_r <= {byte_sh_r[6:0], 1'b0};
		end
	end

	always_ff @(negedge sck_i or posedge cs_n_i)
	begin
		if (cs_n_i)
			so_oe_n_o <= 1'b1;
		else if (stat_act_r)
			so_oe_n_o <= 1'b0;
	end

	// System side: chip select and command-complete pass three flops.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cs_q_r <= 3'h7;
			full_q_r <= 3'h0;
		end
		else
		begin
			cs_q_r <= {cs_q_r[1:0], cs_n_i};
			full_q_r <= {full_q_r[1:0], cmd_full_r};
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			cs_lvl_r <= 1'b1;
		else if (cs_q_r[1] == cs_q_r[2])
			cs_lvl_r <= cs_q_r[2];
	end

	assign cs_rise = cs_q_r[1] && cs_q_r[2] && !cs_lvl_r;
	assign cs_fall = !cs_q_r[1] && !cs_q_r[2] && cs_lvl_r;

	// The full flag is seen well before chip select rises, because the
	// host needs at least half a link clock between its last edge and the
	// rise; pending holds the result over the flag's own reset.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			pending_r <= 1'b0;
		else if (full_q_r[1] && full_q_r[2])
			pending_r <= 1'b1;
		else if (cs_fall || cs_rise)
			pending_r <= 1'b0;
	end

	assign opc = cmd_r[31:24];
	assign start = cs_rise && pending_r && state_r == ST_IDLE;
	assign busy = (state_r != ST_IDLE) || ext_busy_i;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_r <= ST_IDLE;
			arr_req_o <= 1'b0;
			arr_op_o <= FPBSC_OP_XFER;
			arr_page_o <= '0;
			arr_buf_two_o <= 1'b0;
		end
		else
		begin
			arr_req_o <= 1'b0;
			unique case (state_r)
				ST_IDLE:
				begin
					arr_page_o <= fpbsc_page(cmd_r[23:0], page_bin_i);
					if (start && ((opc == OPC_XFER_B1 && !prog_suspended_buf_one_i) ||
						(opc == OPC_XFER_B2 && !prog_suspended_buf_two_i)))
					begin
						state_r <= ST_XFER;
						arr_req_o <= 1'b1;
						arr_op_o <= FPBSC_OP_XFER;
						arr_buf_two_o <= (opc == OPC_XFER_B2);
					end
					else if (start && (opc == OPC_COMP_B1 || opc == OPC_COMP_B2))
					begin
						state_r <= ST_COMP;
						arr_req_o <= 1'b1;
						arr_op_o <= FPBSC_OP_COMP;
						arr_buf_two_o <= (opc == OPC_COMP_B2);
					end
					else if (start && ((opc == OPC_RWR_B1 && !prog_suspended_buf_one_i) ||
						(opc == OPC_RWR_B2 && !prog_suspended_buf_two_i)))
					begin
						state_r <= ST_RWX;
						arr_req_o <= 1'b1;
						arr_op_o <= FPBSC_OP_XFER;
						arr_buf_two_o <= (opc == OPC_RWR_B2);
					end
				end
				ST_XFER, ST_COMP, ST_RWP:
				begin
					if (arr_done_i)
						state_r <= ST_IDLE;
				end
				ST_RWX:
				begin
					if (arr_done_i)
					begin
						state_r <= ST_RWP;
						arr_req_o <= 1'b1;
						arr_op_o <= FPBSC_OP_PROG;
					end
				end
				default:
					state_r <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			comp_r <= 1'b0;
		else if (state_r == ST_COMP && arr_done_i)
			comp_r <= arr_mismatch_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			epe_r <= 1'b0;
		else if (state_r == ST_RWP && arr_done_i)
			epe_r <= arr_fail_i && !arr_abort_i;
		else if (ext_pe_done_i)
			epe_r <= ext_pe_fail_i && !ext_pe_abort_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			status_r <= '0;
		else
		begin
			status_r[8+SB_BUSY_N] <= !busy;
			status_r[8+SB1_COMP] <= comp_r;
			status_r[8+SB1_DENS_LSB +: 4] <= DENSITY_CODE;
			status_r[8+SB1_PROTECT] <= protect_i;
			status_r[8+SB1_PAGE_BIN] <= page_bin_i;
			status_r[SB_BUSY_N] <= !busy;
			status_r[SB2_RES_HI] <= 1'b0;
			status_r[SB2_EPE] <= epe_r;
			status_r[SB2_RES_LO] <= 1'b0;
			status_r[SB2_LOCK_OK] <= lockdown_allowed_i;
			status_r[SB2_PS2] <= prog_suspended_buf_two_i;
			status_r[SB2_PS1] <= prog_suspended_buf_one_i;
			status_r[SB2_ES] <= erase_suspended_i;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence xfer_cmd_s;
		start && opc == OPC_XFER_B1 && !prog_suspended_buf_one_i;
	endsequence

	sequence rw_done_s;
		state_r == ST_RWX && arr_done_i;
	endsequence

	xfer_start_a: assert property (xfer_cmd_s |=> arr_req_o &&
		arr_op_o == FPBSC_OP_XFER && !arr_buf_two_o ##1 !status_r[8+SB_BUSY_N])
		else $error("transfer did not start with busy");
	comp_result_a: assert property (state_r == ST_COMP && arr_done_i |=>
		##1 status_r[8+SB1_COMP] == $past(arr_mismatch_i, 2))
		else $error("compare result not reported");
	rewrite_seq_a: assert property (rw_done_s |=> arr_req_o &&
		arr_op_o == FPBSC_OP_PROG && state_r == ST_RWP)
		else $error("rewrite did not program after transfer");
	epe_abort_a: assert property (state_r == ST_RWP && arr_done_i &&
		arr_abort_i |=> ##1 !status_r[SB2_EPE])
		else $error("error flag set on abort");
	suspend_block_a: assert property (start && opc == OPC_XFER_B2 &&
		prog_suspended_buf_two_i |=> !arr_req_o && state_r == ST_IDLE)
		else $error("suspended buffer modified");
	short_cmd_a: assert property (cs_rise && !pending_r |=> !arr_req_o)
		else $error("operation started on short command");
	busy_hold_a: assert property (state_r != ST_IDLE && !arr_done_i |=>
		!status_r[SB_BUSY_N] && !status_r[8+SB_BUSY_N])
		else $error("ready shown while busy");
	reserved_zero_a: assert property (!status_r[SB2_RES_HI] &&
		!status_r[SB2_RES_LO])
		else $error("reserved bits not zero");
	so_release_a: assert property (@(negedge sck_i) disable iff (cs_n_i)
		!so_oe_n_o |-> stat_act_r)
		else $error("output driven outside status read");

endmodule : fpbsc_top

// ==== fpbsc_host.sv ====
// SPI host model that frames commands and collects status bits.
`timescale 1ns/100ps
module fpbsc_host
(
	// Serial link to the device.
	output logic sck_o,
	output logic cs_n_o,
	output logic si_o,
	input wire logic so_i
);
	initial
	begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		si_o = 1'b0;
	end

	// Mode 0 frame; the clock stands still outside frames.
	task automatic frame(input logic [31:0] cmd, input int nb,
		input int nr, output logic [31:0] rd);
		rd = 32'h0000_0000;
		cs_n_o = 1'b0;
		for (int i = 0; i < nb + nr; i++)
		begin
			if (i < nb)
				si_o = cmd[31 - i];
			else
				si_o = ~si_o;
			#24 sck_o = 1'b1;
			if (i >= nb)
				rd = {rd[30:0], so_i};
			#24 sck_o = 1'b0;
		end
		#24 cs_n_o = 1'b1;
		// A released input toggles, so a stale level never looks like data.
		si_o = ~si_o;
		#100;
	endtask : frame
endmodule : fpbsc_host

// ==== tb_top.sv ====
// Self-checking bench for the page buffer and status command block.
`timescale 1ns/100ps
module tb_top;
	import fpbsc_pkg::*;
	localparam logic [3:0] DEN = 4'h0;
	logic clk_i, rst_i, sck, cs_n, si, so, so_oe_n;
	logic protect, page_bin, lock_ok, ps1, ps2, es, ext_busy;
	logic pe_done, pe_fail, pe_abort;
	logic arr_req, arr_buf_two, arr_done, arr_mm, arr_fail, arr_abort;
	logic comp_x, epe_x;
	fpbsc_op_e arr_op;
	logic [PAGE_W-1:0] arr_page;
	logic [31:0] rd;
	logic [15:0] exp_q[$];
	logic [7:0] opc_t[6] = '{OPC_XFER_B1, OPC_XFER_B2, OPC_COMP_B1,
		OPC_COMP_B2, OPC_RWR_B1, OPC_RWR_B2};
	int num_errors = 0;
	int samples_checked = 0;
	int seed = 72907;

	fpbsc_host host (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so));

	fpbsc_top #(.DENSITY_CODE(DEN)) uut (.clk_i(clk_i), .rst_i(rst_i),
		.sck_i(sck), .cs_n_i(cs_n), .si_i(si), .so_o(so),
		.so_oe_n_o(so_oe_n), .protect_i(protect), .page_bin_i(page_bin),
		.lockdown_allowed_i(lock_ok), .prog_suspended_buf_one_i(ps1),
		.prog_suspended_buf_two_i(ps2), .erase_suspended_i(es),
		.ext_busy_i(ext_busy), .ext_pe_done_i(pe_done),
		.ext_pe_fail_i(pe_fail), .ext_pe_abort_i(pe_abort),
		.arr_req_o(arr_req), .arr_op_o(arr_op), .arr_page_o(arr_page),
		.arr_buf_two_o(arr_buf_two), .arr_done_i(arr_done),
		.arr_mismatch_i(arr_mm), .arr_fail_i(arr_fail),
		.arr_abort_i(arr_abort));

	initial
	begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	task automatic wrap_up;
		if (num_errors == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	function automatic logic [15:0] stat(input logic r);
		stat = {r, comp_x, DEN, protect, page_bin,
			r, 1'b0, epe_x, 1'b0, lock_ok, ps2, ps1, es};
	endfunction : stat

	// Two passes of both bytes, so the wrap to byte one is seen.
	task automatic rd_stat(input logic r);
		host.frame({OPC_STATUS, 24'h0000_00}, 8, 32, rd);
		chk(rd, {stat(r), stat(r)});
		chk(32'(so_oe_n), 32'h0000_0001);
	endtask : rd_stat

	task automatic do_op(input logic [7:0] opc, input int k, input int b);
		logic [12:0] pg;
		logic [23:0] ad;
		@(negedge clk_i);
		pg = 13'($random(seed));
		ad = 24'($random(seed));
		page_bin = 1'($random(seed));
		if (page_bin)
			ad[21:9] = pg;
		else
			ad[22:10] = pg;
		arr_mm = 1'($random(seed));
		arr_fail = 1'($random(seed));
		arr_abort = 1'($random(seed));
		exp_q.push_back({k == 1 ? FPBSC_OP_COMP : FPBSC_OP_XFER, 1'(b), pg});
		if (k == 2)
			exp_q.push_back({FPBSC_OP_PROG, 1'(b), pg});
		host.frame({opc, ad}, 32, 0, rd);
		rd_stat(1'b0);
		if (k == 1)
			comp_x = arr_mm;
		if (k == 2)
			epe_x = arr_fail && !arr_abort;
		repeat (1500) @(negedge clk_i);
		rd_stat(1'b1);
	endtask : do_op

	// Memory core stand-in: answers each request after a long delay.
	// The request is looked at again right after done drops, because a
	// rewrite raises its program request in the cycle after done.
	initial
	begin
		arr_done = 1'b0;
		forever
		begin
			if (arr_req === 1'b1)
			begin
				repeat (600) @(negedge clk_i);
				arr_done = 1'b1;
				@(negedge clk_i);
				arr_done = 1'b0;
			end
			else
				@(negedge clk_i);
		end
	end

	// Each request is matched against the oldest note.
	always @(negedge clk_i)
		if (arr_req === 1'b1)
		begin
			if (exp_q.size() == 0)
				chk(32'h0000_0001, 32'h0000_0000);
			else
				chk({arr_op, arr_buf_two, arr_page}, exp_q.pop_front());
		end

	initial
	begin
		#400000;
		num_errors++;
		wrap_up();
	end

	initial
	begin
		{rst_i, protect, page_bin, lock_ok, ps1, ps2, es} = 7'h40;
		{ext_busy, pe_done, pe_fail, pe_abort} = 4'h0;
		{arr_mm, arr_fail, arr_abort, comp_x, epe_x} = 5'h00;
		repeat (16) @(posedge clk_i);
		@(negedge clk_i);
		rst_i = 1'b0;
		repeat (10) @(negedge clk_i);
		for (int i = 0; i < 4; i++)
		begin
			@(negedge clk_i);
			{protect, lock_ok, ps1, ps2, es} = 5'($random(seed));
			rd_stat(1'b1);
		end
		@(negedge clk_i);
		{ps1, ps2, ext_busy} = 3'h1;
		rd_stat(1'b0);
		ext_busy = 1'b0;
		host.frame({OPC_XFER_B1, 24'h0000_00}, 31, 0, rd);
		ps1 = 1'b1;
		host.frame({OPC_XFER_B1, 24'h0000_00}, 32, 0, rd);
		{ps1, ps2} = 2'h1;
		host.frame({OPC_XFER_B2, 24'h0000_00}, 32, 0, rd);
		repeat (100) @(negedge clk_i);
		{ps1, ps2} = 2'h0;
		foreach (opc_t[i])
			do_op(opc_t[i], i / 2, i % 2);
		for (int k = 0; k < 2; k++)
		begin
			@(negedge clk_i);
			{pe_fail, pe_abort, pe_done} = {1'b1, k[0], 1'b1};
			@(negedge clk_i);
			pe_done = 1'b0;
			epe_x = !k[0];
			rd_stat(1'b1);
		end
		chk(exp_q.size(), 0);
		wrap_up();
	end
endmodule : tb_top
